// ### rtl/bbar_decode.sv
// Address match of one window against an incoming transaction.
// Assumes the caller registers the result; this module is combinational.
`timescale 1ns/1ps
module bbar_decode (
   // Transaction
   input  wire bbar_pkg::bbar_req_type   req,
   // Window description
   input  wire bbar_pkg::bbar_setup_type setup,
   input  wire logic [31:0]              base,
   input  wire logic [31:0]              mask,
   input  wire logic [31:0]              high,
   input  wire logic                     enable,
   // Result
   output      logic                     hit
);

   logic low_match;
   logic high_match;
   logic space_match;

   // ************************************************************
   // Match terms
   // ************************************************************
   // Only the programmed bits take part; the rest select inside the window
   assign low_match   = (req.addr[31:0] & mask) == (base & mask);
   assign high_match  = req.addr[63:32] == high;
   assign space_match = req.is_io == setup.space_select_bit;

   // An empty mask means a disabled window, which never claims anything
   assign hit = enable && req.valid && space_match && (|mask) && low_match && high_match;

endmodule : bbar_decode

// ### rtl/bbar_mask.sv
// Writable-bit mask of one base address field, derived from a size setting.
// Assumes the size setting is stable or changes only between accesses.
`timescale 1ns/1ps
module bbar_mask (
   // Size setting
   input  wire logic [4:0]  size_log2,
   // Bits of the register that software may change
   output      logic [31:0] mask
);

   // ************************************************************
   // Per-bit mask
   // ************************************************************
   // Sizes below 16 bytes still keep the low nibble read-only
   for (genvar gb = 0; gb < 32; gb++) begin : g_bit
      if (gb < bbar_pkg::BASE_LO) begin : g_fixed
         assign mask[gb] = 1'b0;
      end else begin : g_field
         localparam logic [4:0] BITPOS = 5'(gb);
         assign mask[gb] = (size_log2 != bbar_pkg::SIZE_DISABLED) && (BITPOS >= size_log2);
      end
   end

endmodule : bbar_mask

// ### rtl/bbar_pkg.sv
// Constants and carrier types for the bridge base address register bank.
// Assumes a byte-addressed configuration port with 32-bit data.
package bbar_pkg;

   // ************************************************************
   // Register offsets (byte addresses)
   // ************************************************************
   localparam int         ADDR_W         = 8;
   localparam logic [7:0] OFF_BASE_ONE   = 8'h14;
   localparam logic [7:0] OFF_BASE_TWO   = 8'h18;
   localparam logic [7:0] OFF_BASE_THREE = 8'h1c;

   // ************************************************************
   // Field positions inside a base address register
   // ************************************************************
   localparam int SPACE_BIT = 0;
   localparam int TYPE_LO   = 1;
   localparam int TYPE_HI   = 2;
   localparam int PREFETCH_FLAG_BIT  = 3;
   localparam int BASE_LO   = 4;

   // ************************************************************
   // Encodings and reset values
   // ************************************************************
   localparam logic       SPACE_MEM     = 1'b0;
   localparam logic       SPACE_IO      = 1'b1;
   localparam logic [1:0] TYPE_ADDR32   = 2'h0;
   localparam logic [1:0] TYPE_ADDR64   = 2'h2;
   localparam logic       PREFETCH_FLAG_NONE     = 1'b0;
   localparam logic [4:0] SIZE_DISABLED = 5'h00;
   localparam logic [31:0] BASE_RESET   = 32'h0000_0000;
   localparam logic [31:0] RD_UNMAPPED  = 32'h0000_0000;
   localparam logic [31:0] HIGH_NONE    = 32'h0000_0000;

   // ************************************************************
   // Carrier types
   // ************************************************************
   // One window setup: size_log2 is log2 of the window in bytes, zero disables
   typedef struct packed {
      logic       space_select_bit;
      logic [1:0] addr_type;
      logic       prefetch_flag;
      logic [4:0] size_log2;
   } bbar_setup_type;

   // One incoming transaction to be decoded
   typedef struct packed {
      logic        valid;
      logic        is_io;
      logic [63:0] addr;
   } bbar_req_type;

endpackage : bbar_pkg

// ### rtl/bbar_regs.sv
// Base address registers one to three of a bridge endpoint, with decode.
// Assumes the window setups come from elsewhere and the bus never waits.
//
// Behaviour
// - Setup zero memory 64-bit: register one holds upper half of window zero.
// - Setup two memory 64-bit: register three holds upper half of window two.
// - Bit 0 is read-only unless serving as an upper half, mirrors setup space select: 0 memory, 1 I/O.
// - Odd registers report type 0x0, the 32-bit format, unless serving as an upper half.
// - Register two type bits mirror setup type: 0x0 32-bit, 0x2 64-bit.
// - I/O space forces the type field to zero.
// - Bit 3 mirrors setup prefetch flag unless serving as an upper half, forced to zero for I/O.
// - Bits 31:4 reset to zero; only size-allowed bits write, others read zero, except an upper half, where all 32 bits write.
// - Programmed base bits decide which incoming transactions the bridge claims.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module bbar_regs (
   // Clock and reset
   input  wire logic                                 ref_clk,
   input  wire logic                                 rst_n,
   // Register port
   input  wire logic [bbar_pkg::ADDR_W-1:0]          reg_addr,
   input  wire logic [31:0]                          reg_wdata,
   input  wire logic                                 reg_wr,
   input  wire logic                                 reg_rd,
   output      logic [31:0]                          reg_rdata,
   // Window setups
   input  wire bbar_pkg::bbar_setup_type             window_setup_zero,
   input  wire bbar_pkg::bbar_setup_type             window_setup_one,
   input  wire bbar_pkg::bbar_setup_type             window_setup_two,
   input  wire bbar_pkg::bbar_setup_type             window_setup_three,
   // Incoming transaction
   input  wire bbar_pkg::bbar_req_type               req,
   // Decode results, one cycle after the request
   output      logic [2:0]                           win_hit,
   output      logic                                 win_hit_valid,
   // Upper address half lent to window zero
   output      logic [31:0]                          zero_high_addr
);

   // ************************************************************
   // Declarations
   // ************************************************************
   bbar_pkg::bbar_setup_type setup_of [3];
   logic [bbar_pkg::ADDR_W-1:0] offset_of [3];
   logic [31:0] base      [3];
   logic [31:0] next_base [3];
   logic [31:0] wmask     [3];
   logic [31:0] view      [3];
   logic [31:0] high_of   [3];
   logic [2:0]  as_upper;
   logic [2:0]  enable_of;
   logic [2:0]  wr_sel;
   logic [2:0]  hit_now;
   logic        pair_low;
   logic        pair_high;
   logic [31:0] next_rdata;
   logic [2:0]  next_win_hit;
   logic        next_win_hit_valid;
   logic [31:0] next_zero_high_addr;

   // ************************************************************
   // Window setups and offsets as arrays
   // ************************************************************
   // Index 0, 1, 2 stands for registers one, two, three
   assign setup_of[0]  = window_setup_one;
   assign setup_of[1]  = window_setup_two;
   assign setup_of[2]  = window_setup_three;
   assign offset_of[0] = bbar_pkg::OFF_BASE_ONE;
   assign offset_of[1] = bbar_pkg::OFF_BASE_TWO;
   assign offset_of[2] = bbar_pkg::OFF_BASE_THREE;

   // ************************************************************
   // Pairing of registers into 64-bit windows
   // ************************************************************
   // Register one becomes the upper half of window zero
   assign pair_low = (window_setup_zero.space_select_bit == bbar_pkg::SPACE_MEM) &&
                     (window_setup_zero.addr_type == bbar_pkg::TYPE_ADDR64);

   // Register three becomes the upper half of window two
   assign pair_high = (window_setup_two.space_select_bit == bbar_pkg::SPACE_MEM) &&
                      (window_setup_two.addr_type == bbar_pkg::TYPE_ADDR64);

   // Which registers currently act as a plain upper half
   assign as_upper = {pair_high, 1'b0, pair_low};

   // A register serving as an upper half owns no window of its own
   assign enable_of = ~as_upper;

   // Upper half that each window compares against
   assign high_of[0] = bbar_pkg::HIGH_NONE;
   assign high_of[1] = pair_high ? base[2] : bbar_pkg::HIGH_NONE;
   assign high_of[2] = bbar_pkg::HIGH_NONE;

   // ************************************************************
   // Per-register logic
   // ************************************************************
   for (genvar gi = 0; gi < 3; gi++) begin : g_reg

      // Writable bits follow the size of the matching setup
      bbar_mask u_mask (
         .size_log2 (setup_of[gi].size_log2),
         .mask      (wmask[gi])
      );

      // Write select; the bus never issues read and write together
      assign wr_sel[gi] = reg_wr && (reg_addr == offset_of[gi]);

      // Read view of the register
      always_comb begin
         logic [1:0] type_bits;
         logic       prefetch_flag_bit;
         type_bits = bbar_pkg::TYPE_ADDR32;
         prefetch_flag_bit  = setup_of[gi].prefetch_flag;
         if (gi == 1) begin
            type_bits = setup_of[gi].addr_type;
         end
         if (setup_of[gi].space_select_bit == bbar_pkg::SPACE_IO) begin
            type_bits = bbar_pkg::TYPE_ADDR32;
            prefetch_flag_bit  = bbar_pkg::PREFETCH_FLAG_NONE;
         end
         if (as_upper[gi]) begin
            // Whole word is address; no flag bits live here
            view[gi] = base[gi];
         end else begin
            // Masking on read too keeps a later size change honest
            view[gi] = {base[gi][31:bbar_pkg::BASE_LO] & wmask[gi][31:bbar_pkg::BASE_LO],
                        prefetch_flag_bit,
                        type_bits,
                        setup_of[gi].space_select_bit};
         end
      end

      // Next stored value
      always_comb begin
         next_base[gi] = base[gi];
         if (wr_sel[gi]) begin
            if (as_upper[gi]) begin
               next_base[gi] = reg_wdata;
            end else begin
               // Low nibble is never stored; its bits come from the setup
               next_base[gi] = {reg_wdata[31:bbar_pkg::BASE_LO] & wmask[gi][31:bbar_pkg::BASE_LO],
                                4'h0};
            end
         end
      end

      // Stored value, cleared by reset
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            base[gi] <= bbar_pkg::BASE_RESET;
         end else begin
            base[gi] <= next_base[gi];
         end
      end

      // Window match against the incoming transaction
      bbar_decode u_decode (
         .req    (req),
         .setup  (setup_of[gi]),
         .base   (base[gi]),
         .mask   (wmask[gi]),
         .high   (high_of[gi]),
         .enable (enable_of[gi]),
         .hit    (hit_now[gi])
      );
   end

   // ************************************************************
   // Read data
   // ************************************************************
   // Data stands only in the cycle after the strobe, zero otherwise
   always_comb begin
      next_rdata = bbar_pkg::RD_UNMAPPED;
      if (reg_rd) begin
         if (reg_addr == bbar_pkg::OFF_BASE_ONE) begin
            next_rdata = view[0];
         end else if (reg_addr == bbar_pkg::OFF_BASE_TWO) begin
            next_rdata = view[1];
         end else if (reg_addr == bbar_pkg::OFF_BASE_THREE) begin
            next_rdata = view[2];
         end else begin
            next_rdata = bbar_pkg::RD_UNMAPPED;
         end
      end
   end

   // ************************************************************
   // Decode results and lent upper half
   // ************************************************************
   // Registering costs one cycle of latency but keeps outputs glitch-free
   always_comb begin
      next_win_hit        = hit_now;
      next_win_hit_valid  = req.valid;
      next_zero_high_addr = bbar_pkg::HIGH_NONE;
      if (pair_low) begin
         next_zero_high_addr = base[0];
      end
   end

   // ************************************************************
   // Output registers
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata      <= bbar_pkg::RD_UNMAPPED;
         win_hit        <= 3'h0;
         win_hit_valid  <= 1'b0;
         zero_high_addr <= bbar_pkg::HIGH_NONE;
      end else begin
         reg_rdata      <= next_rdata;
         win_hit        <= next_win_hit;
         win_hit_valid  <= next_win_hit_valid;
         zero_high_addr <= next_zero_high_addr;
      end
   end

endmodule : bbar_regs

// ### test/bbar_regs_sva.sv
// Checker for the base address register bank: read view and decode timing.
// Assumes it is bound to bbar_regs and that setups stay steady around a read.
`timescale 1ns/1ps
module bbar_regs_sva (
   // Clock and reset
   input wire logic                        ref_clk,
   input wire logic                        rst_n,
   // Register port
   input wire logic [bbar_pkg::ADDR_W-1:0] reg_addr,
   input wire logic                        reg_rd,
   input wire logic [31:0]                 reg_rdata,
   // Setups and decode
   input wire bbar_pkg::bbar_setup_type    window_setup_zero,
   input wire bbar_pkg::bbar_setup_type    window_setup_two,
   input wire bbar_pkg::bbar_req_type      req,
   input wire logic [2:0]                  win_hit,
   input wire logic                        win_hit_valid,
   input wire logic [31:0]                 zero_high_addr
);
   // ************************************************************
   // Helpers
   // ************************************************************
   // Lending happens only on memory space with type exactly 0x2
   logic up1;
   logic up3;
   logic rd2;
   assign up1 = !window_setup_zero.space_select_bit && window_setup_zero.addr_type == 2'h2;
   assign up3 = !window_setup_two.space_select_bit && window_setup_two.addr_type == 2'h2;
   assign rd2 = reg_rd && reg_addr == bbar_pkg::OFF_BASE_TWO;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // ************************************************************
   // Assertions
   // ************************************************************
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data seen outside a read cycle");
   space_mirror_a: assert property (rd2 |=> reg_rdata[0] == $past(window_setup_two.space_select_bit))
      else $error("space bit differs from setup");
   odd_type_a: assert property (reg_rd && ((reg_addr == bbar_pkg::OFF_BASE_ONE && !up1)
      || (reg_addr == bbar_pkg::OFF_BASE_THREE && !up3)) |=> reg_rdata[2:1] == 2'h0) else $error("odd type not zero");
   two_type_a: assert property (rd2 && !window_setup_two.space_select_bit
      |=> reg_rdata[2:1] == $past(window_setup_two.addr_type)) else $error("type differs from setup");
   io_type_a: assert property (rd2 && window_setup_two.space_select_bit |=> reg_rdata[2:1] == 2'h0)
      else $error("io type not zero");
   prefetch_flag_flag_a: assert property (rd2 |=> reg_rdata[3] == $past(window_setup_two.prefetch_flag
      & ~window_setup_two.space_select_bit)) else $error("prefetch flag wrong");
   size_mask_a: assert property (rd2 && window_setup_two.size_log2 > 5'h04 |=> (reg_rdata[31:4]
      & ~(28'hfffffff << ($past(window_setup_two.size_log2) - 5'h04))) == 28'h0) else $error("base bit outside size");
   high_zero_a: assert property (!up1 |=> zero_high_addr == 32'h0)
      else $error("upper half shown while not lent");
   hit_valid_a: assert property (req.valid |=> win_hit_valid)
      else $error("decode result missing");
   hit_idle_a: assert property (!req.valid |=> win_hit == 3'h0 && !win_hit_valid)
      else $error("decode result without request");
   lent_nohit_a: assert property (req.valid && up3 |=> !win_hit[2])
      else $error("lent register claimed a transaction");
   // Main scenarios
   cover property (rd2 && up3);
   cover property (req.valid ##1 win_hit != 3'h0);
   cover property (reg_rd && reg_addr == bbar_pkg::OFF_BASE_ONE && up1);
endmodule : bbar_regs_sva
bind bbar_regs bbar_regs_sva i_bbar_regs_sva (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .window_setup_zero(window_setup_zero), .window_setup_two(window_setup_two),
   .req(req), .win_hit(win_hit), .win_hit_valid(win_hit_valid), .zero_high_addr(zero_high_addr));

// ### test/bbar_regs_tb.sv
// Self-checking bench for the base address register bank.
// Assumes setups are levels held by the bench and the bus never waits.
`timescale 1ns/1ps
module bbar_regs_tb;
   logic                     ref_clk   = 1'b0;
   logic                     rst_n     = 1'b0;
   logic [7:0]               reg_addr  = 8'h00;
   logic [31:0]              reg_wdata = 32'h0;
   logic                     reg_wr    = 1'b0;
   logic                     reg_rd    = 1'b0;
   logic [31:0]              reg_rdata;
   bbar_pkg::bbar_setup_type su [4]    = '{default: '0};
   bbar_pkg::bbar_req_type   req       = '0;
   logic [2:0]               win_hit;
   logic                     win_hit_valid;
   logic [31:0]              zero_high_addr;
   logic [31:0]              st [1:3]  = '{default: 32'h0};
   logic [31:0]              rd_q [$];
   logic [31:0]              hit_q [$];
   logic                     rd_dly    = 1'b0;
   logic                     hv_dly    = 1'b0;
   int                       err_count = 0;
   int                       tests_run = 0;
   // 25 MHz clock
   always #20 ref_clk = ~ref_clk;
   bbar_regs i_bbar_regs (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .window_setup_zero(su[0]),
      .window_setup_one(su[1]), .window_setup_two(su[2]), .window_setup_three(su[3]), .req(req),
      .win_hit(win_hit), .win_hit_valid(win_hit_valid), .zero_high_addr(zero_high_addr));
   // ************************************************************
   // Reference model
   // ************************************************************
   // Sizes below 4 act like 4, since the low nibble never stores
   function automatic logic [31:0] msk(int i);
      if (su[i].size_log2 == 5'h00) return 32'h0;
      return 32'hffffffff << ((su[i].size_log2 < 5'h04) ? 5'h04 : su[i].size_log2);
   endfunction : msk
   function automatic logic upper(int i);
      return i != 2 && !su[i-1].space_select_bit && su[i-1].addr_type == 2'h2;
   endfunction : upper
   function automatic int idx(logic [7:0] a);
      return (a == 8'h14) ? 1 : (a == 8'h18) ? 2 : (a == 8'h1c) ? 3 : 0;
   endfunction : idx
   function automatic logic [31:0] view(int i);
      logic [31:0] v;
      if (upper(i)) return st[i];
      v = st[i] & msk(i);
      v[0] = su[i].space_select_bit;
      v[3] = su[i].prefetch_flag & ~su[i].space_select_bit;
      if (i == 2 && !su[2].space_select_bit) v[2:1] = su[2].addr_type;
      return v;
   endfunction : view
   function automatic logic hit(int i, logic [63:0] a, logic io);
      logic [31:0] hi;
      hi = (i == 2 && upper(3)) ? st[3] : 32'h0;
      return !upper(i) && msk(i) != 32'h0 && io == su[i].space_select_bit
         && ((a[31:0] ^ st[i]) & msk(i)) == 32'h0 && a[63:32] == hi;
   endfunction : hit
   // ************************************************************
   // Drivers
   // ************************************************************
   // Every driver call applies its values on the next rising edge and holds them until the next driver call
   task automatic drive(logic w, logic r, logic [7:0] a, logic [31:0] d, bbar_pkg::bbar_req_type q);
      @(posedge ref_clk);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      req <= q;
   endtask : drive
   task automatic wr(logic [7:0] ad, logic [31:0] d);
      drive(1'b1, 1'b0, ad, d, '0);
      if (idx(ad) != 0) st[idx(ad)] = upper(idx(ad)) ? d : d & msk(idx(ad));
   endtask : wr
   task automatic rd(logic [7:0] ad);
      drive(1'b0, 1'b1, ad, 32'h0, '0);
      rd_q.push_back(idx(ad) != 0 ? view(idx(ad)) : 32'h0);
   endtask : rd
   task automatic probe(logic io, logic [63:0] a);
      drive(1'b0, 1'b0, reg_addr, reg_wdata, {1'b1, io, a});
      hit_q.push_back({29'h0, hit(3, a, io), hit(2, a, io), hit(1, a, io)});
   endtask : probe
   task automatic newsu();
      drive(1'b0, 1'b0, 8'h00, 32'h0, '0);
      for (int k = 0; k < 4; k++) su[k] <= 9'($urandom());
   endtask : newsu
   task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", n, exp, seen);
      end
   endtask : check
   task automatic print_verdict();
      if (err_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict
   // Monitor: results stand one cycle after their request
   always @(posedge ref_clk) begin
      rd_dly <= reg_rd && rst_n;
      hv_dly <= req.valid && rst_n;
   end
   always @(negedge ref_clk) begin
      if (rd_dly) check("reg_rdata", reg_rdata, rd_q.pop_front());
      else check("reg_rdata idle", reg_rdata, 32'h0);
      check("win_hit_valid", {31'h0, win_hit_valid}, {31'h0, hv_dly});
      if (hv_dly) check("win_hit", {29'h0, win_hit}, hit_q.pop_front());
      else check("win_hit idle", {29'h0, win_hit}, 32'h0);
   end
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      logic [63:0] a;
      void'($urandom(32'h275e99c6));
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int n = 0; n < 300; n++) begin
         // Mid-run reset must clear every stored base
         if (n == 150) begin
            drive(1'b0, 1'b0, 8'h00, 32'h0, '0);
            @(posedge ref_clk);
            rst_n <= 1'b0;
            st = '{default: 32'h0};
            repeat (3) @(posedge ref_clk);
            rst_n <= 1'b1;
         end
         // New setups first, so stored words are seen through a changed mode
         newsu();
         for (int i = 1; i <= 3; i++) rd(8'(8'h10 + 4 * i));
         for (int i = 1; i <= 3; i++) begin
            wr(8'(8'h10 + 4 * i), $urandom());
            rd(8'(8'h10 + 4 * i));
         end
         wr(8'h20, $urandom());
         rd(8'h15);
         rd(8'h20);
         // Aim inside each window, back to back, then one random address
         for (int i = 1; i <= 3; i++) begin
            a = {(i == 2 && upper(3)) ? st[3] : 32'h0, st[i] ^ ($urandom() & ~msk(i))};
            probe(su[i].space_select_bit, a);
         end
         probe(1'($urandom()), {$urandom(), $urandom()});
         drive(1'b0, 1'b0, 8'h00, 32'h0, '0);
         @(negedge ref_clk);
         check("zero_high_addr", zero_high_addr, upper(1) ? st[1] : 32'h0);
      end
      for (int t = 0; t < 4 && rd_q.size() + hit_q.size() != 0; t++) @(posedge ref_clk);
      if (rd_q.size() + hit_q.size() != 0) err_count++;
      print_verdict();
   end
endmodule : bbar_regs_tb
